/* src/ow_check_ctrl.sv */
// open-wire and balance-switch comparison control with APB registers
// assumes converter samples arrive as one-cycle strobes on ref_clk_i
//
// The placing of the registers and the APB register port were chosen for this implementation.
module ow_check_ctrl (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // converter state and results
    input wire logic main_on_i,
    input wire logic main_cont_i,
    input wire logic aux_on_i,
    input wire logic aux_cont_i,
    input wire logic cb_active_i,
    input wire logic cb_paused_i,
    input wire ow_pkg::sample_t main_sample_i,
    input wire ow_pkg::sample_t aux_sample_i,
    input wire ow_pkg::sample_t busbar_sample_i,
    // pin sinks, sources and converter setup
    output logic [15:0] sense_sink_o,
    output logic sense_source_o,
    output logic [15:0] bal_sink_o,
    output logic bal_source_o,
    output logic busbar_sink_o,
    output logic [1:0] aux_settling_o,
    output logic [2:0] cell_filter_o,
    output logic [2:0] busbar_filter_o,
    output logic [2:0] busbar_gain_o,
    output logic busy_o
);

    // -------------------------------------------------------------
    // registers and state
    // -------------------------------------------------------------
    ow_pkg::ctrl_t ctrl;
    ow_pkg::cfg_t cfg;
    ow_pkg::state_t state;
    ow_pkg::chk_t chk;
    logic [15:0] bb_pos;
    logic [15:0] sw_sel;
    logic [4:0] stat;
    logic [15:0] sw_res;
    logic [15:0] vc_res;
    logic [15:0] cb_res;
    logic [15:0] aux_res;
    logic [15:0] dsec_res;
    logic [15:0] bb_res;
    logic [15:0] cell_res [16];
    logic [2:0] run_sel;
    logic [15:0] need;
    logic [15:0] seen;
    logic [15:0] acc;

    ow_setup_check u_chk (
        .cfg_i(cfg),
        .bb_pos_i(bb_pos),
        .sw_sel_i(sw_sel),
        .main_on_i(main_on_i),
        .main_cont_i(main_cont_i),
        .aux_on_i(aux_on_i),
        .aux_cont_i(aux_cont_i),
        .cb_active_i(cb_active_i),
        .cb_paused_i(cb_paused_i),
        .chk_o(chk)
    );

    // -------------------------------------------------------------
    // bus decode
    // -------------------------------------------------------------
    wire setup = psel_i & ~penable_i;
    wire wr = psel_i & penable_i & pready_o & pwrite_i;
    wire [11:0] a = paddr_i;
    wire is_cell = a[11:6] == ow_pkg::CELL_WIN;
    wire mapped = is_cell | (a <= ow_pkg::A_BBRES && a[1:0] == 2'b00);
    wire [31:0] next_prdata =
        is_cell ? {16'h0000, cell_res[a[5:2]]} :
        a == ow_pkg::A_CTRL ? 32'(ctrl) :
        a == ow_pkg::A_CFG ? 32'(cfg) :
        a == ow_pkg::A_BBPOS ? {16'h0000, bb_pos} :
        a == ow_pkg::A_SWSEL ? {16'h0000, sw_sel} :
        a == ow_pkg::A_STAT ? {23'h000000, busy_o, 3'h0, stat} :
        a == ow_pkg::A_SWRES ? {16'h0000, sw_res} :
        a == ow_pkg::A_VCRES ? {16'h0000, vc_res} :
        a == ow_pkg::A_CBRES ? {16'h0000, cb_res} :
        a == ow_pkg::A_AUXRES ? {16'h0000, aux_res} :
        a == ow_pkg::A_DSEC ? {16'h0000, dsec_res} :
        // main path has no single-channel lock, so nothing lands here
        a == ow_pkg::A_DPRI ? {16'h0000, ow_pkg::RES_DEF} :
        a == ow_pkg::A_BBRES ? {16'h0000, bb_res} : 32'h00000000;
    wire go = wr & (a == ow_pkg::A_CTRL) & pwdata_i[ow_pkg::GO_BIT];
    wire [4:0] st_clr = (wr && a == ow_pkg::A_STAT)
        ? pwdata_i[ow_pkg::ST_W-1:0] : 5'h00;

    // -------------------------------------------------------------
    // start screening and channel needs
    // -------------------------------------------------------------
    // the select code is the one written together with go
    wire [2:0] go_sel = pwdata_i[2:0];
    wire locked = cfg.aux_sel != 5'h00 && !chk.aux_sel_bad;
    wire [3:0] lidx = 4'(cfg.aux_sel - 5'h01);
    wire [15:0] lbit = 16'h0001 << lidx;
    wire [16:0] act_w = (17'h00001 << cfg.num_cell) - 17'h00001;
    wire [15:0] act = act_w[15:0];
    wire sw_abort = chk.aux_sel_bad | chk.over_count | chk.bb_bad
        | chk.main_bad | chk.aux_adc_bad | chk.cb_bad
        | chk.sw_bad;
    wire vc_abort = chk.main_bad;
    wire cb_abort = chk.aux_adc_bad | chk.aux_sel_bad | chk.over_count;
    wire sel_ok = go_sel == ow_pkg::SEL_VC || go_sel == ow_pkg::SEL_CB
        || go_sel == ow_pkg::SEL_SW;
    wire start_abort = (go_sel == ow_pkg::SEL_SW) ? sw_abort :
        (go_sel == ow_pkg::SEL_CB) ? cb_abort : vc_abort;
    wire start = go & sel_ok & (state == ow_pkg::ST_IDLE);
    wire abort = start & start_abort;
    wire launch = start & ~start_abort;
    // every needed channel (all active ones, the selected switches on active cells, or the locked channel) must report before the run ends
    wire [15:0] next_need = (go_sel == ow_pkg::SEL_VC) ? act :
        (go_sel == ow_pkg::SEL_SW) ? (sw_sel & act) :
        locked ? lbit : act;

    // -------------------------------------------------------------
    // sample comparison
    // -------------------------------------------------------------
    wire running = state == ow_pkg::ST_RUN;
    wire [15:0] mbit = 16'h0001 << main_sample_i.chan;
    wire [15:0] abit = 16'h0001 << aux_sample_i.chan;
    wire mhit = running & main_sample_i.valid
        & (run_sel == ow_pkg::SEL_VC) & |(need & mbit);
    wire ahit = running & aux_sample_i.valid
        & (run_sel != ow_pkg::SEL_VC) & |(need & abit);
    wire [15:0] half = cell_res[aux_sample_i.chan] >> 1;
    wire afault = (run_sel == ow_pkg::SEL_SW)
        ? (aux_sample_i.value >= half)
        : ow_pkg::ow_low(aux_sample_i.value, ctrl.thr);
    wire mfault = ow_pkg::ow_low(main_sample_i.value, ctrl.thr);
    wire [15:0] next_seen = seen | (mhit ? mbit : 16'h0000)
        | (ahit ? abit : 16'h0000);
    wire [15:0] next_acc = acc | ((mhit && mfault) ? mbit : 16'h0000)
        | ((ahit && afault) ? abit : 16'h0000);
    wire done = running & ((next_seen & need) == need);
    wire lock_cap = ahit & locked;

    // ready events; set wins over a same-cycle clear
    wire [4:0] st_set;
    assign st_set[ow_pkg::ST_ABORT] = abort;
    assign st_set[ow_pkg::ST_AUXRDY] = (abort && go_sel != ow_pkg::SEL_VC)
        || (done && run_sel == ow_pkg::SEL_SW);
    assign st_set[ow_pkg::ST_SWRDY] = (abort && go_sel == ow_pkg::SEL_SW)
        || (done && run_sel == ow_pkg::SEL_SW);
    assign st_set[ow_pkg::ST_VCRDY] = (abort && go_sel == ow_pkg::SEL_VC)
        || (done && run_sel == ow_pkg::SEL_VC);
    assign st_set[ow_pkg::ST_CBRDY] = (abort && go_sel == ow_pkg::SEL_CB)
        || (done && run_sel == ow_pkg::SEL_CB);

    // -------------------------------------------------------------
    // apb response
    // -------------------------------------------------------------
    // one wait-free access phase: answer prepared during setup
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h00000000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (ce_i) begin
            pready_o <= setup;
            pslverr_o <= setup & ~mapped;
            prdata_o <= (setup && !pwrite_i) ? next_prdata : 32'h00000000;
        end
    end

    // -------------------------------------------------------------
    // software-written configuration
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl <= '0;
            cfg <= '{bb_filt: 3'h0, cell_filt: 3'h0, settle: 2'h0,
                     aux_sel: 5'h00, num_cell: ow_pkg::NCELL_RST};
            bb_pos <= 16'h0000;
            sw_sel <= 16'h0000;
        end else if (ce_i && wr) begin
            if (a == ow_pkg::A_CTRL) begin
                ctrl <= ow_pkg::ctrl_t'(pwdata_i[8:0]);
            end
            if (a == ow_pkg::A_CFG) begin
                cfg <= ow_pkg::cfg_t'(pwdata_i[17:0]);
            end
            if (a == ow_pkg::A_BBPOS) begin
                bb_pos <= pwdata_i[15:0];
            end
            if (a == ow_pkg::A_SWSEL) begin
                sw_sel <= pwdata_i[15:0];
            end
        end
    end

    // -------------------------------------------------------------
    // run control
    // -------------------------------------------------------------
    // an aborted start never enters the run state
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ow_pkg::ST_IDLE;
            run_sel <= 3'h0;
            need <= 16'h0000;
            seen <= 16'h0000;
            acc <= 16'h0000;
        end else if (ce_i) begin
            unique case (state)
                ow_pkg::ST_IDLE: begin
                    if (launch) begin
                        state <= ow_pkg::ST_RUN;
                        run_sel <= go_sel;
                        need <= next_need;
                    end
                    seen <= 16'h0000;
                    acc <= 16'h0000;
                end
                ow_pkg::ST_RUN: begin
                    seen <= next_seen;
                    acc <= next_acc;
                    if (done) begin
                        state <= ow_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= ow_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // status flags and result registers
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stat <= 5'h00;
            sw_res <= 16'h0000;
            vc_res <= 16'h0000;
            cb_res <= 16'h0000;
            aux_res <= ow_pkg::RES_DEF;
            dsec_res <= ow_pkg::RES_DEF;
        end else if (ce_i) begin
            stat <= (stat & ~st_clr) | st_set;
            if (abort && go_sel == ow_pkg::SEL_SW) begin
                sw_res <= ow_pkg::RES_ABORT;
            end
            // a bad select leaves aux_res as it was
            if (abort && locked) begin
                aux_res <= ow_pkg::RES_DEF;
            end else if (lock_cap) begin
                aux_res <= aux_sample_i.value;
            end
            if (lock_cap) begin
                dsec_res <= aux_sample_i.value;
            end
            if (done) begin
                if (run_sel == ow_pkg::SEL_SW) begin
                    sw_res <= next_acc;
                end
                if (run_sel == ow_pkg::SEL_VC) begin
                    vc_res <= next_acc;
                end
                if (run_sel == ow_pkg::SEL_CB) begin
                    cb_res <= next_acc;
                end
            end
        end
    end

    // -------------------------------------------------------------
    // measurement results
    // -------------------------------------------------------------
    // bus bars on cell channels land in the cell slot like any cell
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < ow_pkg::NCELL; i++) begin
                cell_res[i] <= ow_pkg::RES_DEF;
            end
            bb_res <= ow_pkg::RES_DEF;
        end else if (ce_i) begin
            if (main_sample_i.valid) begin
                cell_res[main_sample_i.chan] <= main_sample_i.value;
            end
            if (busbar_sample_i.valid) begin
                bb_res <= busbar_sample_i.value;
            end
        end
    end

    // -------------------------------------------------------------
    // pin drive and converter setup
    // -------------------------------------------------------------
    // sinks stay on until software clears the sink field
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sense_sink_o <= 16'h0000;
            sense_source_o <= 1'b0;
            bal_sink_o <= 16'h0000;
            bal_source_o <= 1'b0;
            busbar_sink_o <= 1'b0;
            aux_settling_o <= 2'h0;
            cell_filter_o <= 3'h0;
            busbar_filter_o <= 3'h0;
            busbar_gain_o <= ow_pkg::BB_GAIN_X5;
            busy_o <= 1'b0;
        end else if (ce_i) begin
            sense_sink_o <= {16{ctrl.sink == ow_pkg::SNK_VC}};
            sense_source_o <= ctrl.sink == ow_pkg::SNK_VC;
            bal_sink_o <= {16{ctrl.sink == ow_pkg::SNK_CB}};
            bal_source_o <= ctrl.sink == ow_pkg::SNK_CB;
            busbar_sink_o <= ctrl.sink == ow_pkg::SNK_BB;
            aux_settling_o <= cfg.settle;
            cell_filter_o <= cfg.cell_filt;
            busbar_filter_o <= cfg.bb_filt;
            busbar_gain_o <= ow_pkg::BB_GAIN_X5;
            busy_o <= launch | (running & ~done);
        end
    end

endmodule : ow_check_ctrl

/* src/ow_pkg.sv */
// constants, types and helpers for the open-wire and switch check block
// assumes one 200 MHz core clock and a 32-bit APB register port
package ow_pkg;

    // -------------------------------------------------------------
    // geometry
    // -------------------------------------------------------------
    localparam int NCELL = 16;
    localparam int VW = 16;
    localparam int AW = 12;
    localparam int SW_MAX_ON = 8;
    localparam int BB_MAX_POS = 2;

    // -------------------------------------------------------------
    // register byte offsets
    // -------------------------------------------------------------
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_CFG = 12'h004;
    localparam logic [11:0] A_BBPOS = 12'h008;
    localparam logic [11:0] A_SWSEL = 12'h00c;
    localparam logic [11:0] A_STAT = 12'h010;
    localparam logic [11:0] A_SWRES = 12'h014;
    localparam logic [11:0] A_VCRES = 12'h018;
    localparam logic [11:0] A_CBRES = 12'h01c;
    localparam logic [11:0] A_AUXRES = 12'h020;
    localparam logic [11:0] A_DSEC = 12'h024;
    localparam logic [11:0] A_DPRI = 12'h028;
    localparam logic [11:0] A_BBRES = 12'h02c;
    localparam logic [5:0] CELL_WIN = 6'h01;

    // -------------------------------------------------------------
    // field positions and codes
    // -------------------------------------------------------------
    localparam int GO_BIT = 9;
    localparam int ST_ABORT = 0;
    localparam int ST_AUXRDY = 1;
    localparam int ST_SWRDY = 2;
    localparam int ST_VCRDY = 3;
    localparam int ST_CBRDY = 4;
    localparam int ST_W = 5;
    localparam int ST_BUSY = 8;
    localparam logic [2:0] SEL_VC = 3'h2;
    localparam logic [2:0] SEL_CB = 3'h3;
    localparam logic [2:0] SEL_SW = 3'h4;
    localparam logic [1:0] SNK_OFF = 2'h0;
    localparam logic [1:0] SNK_VC = 2'h1;
    localparam logic [1:0] SNK_CB = 2'h2;
    localparam logic [1:0] SNK_BB = 2'h3;
    localparam logic [2:0] BB_GAIN_X5 = 3'h5;

    // -------------------------------------------------------------
    // reset and abort values
    // -------------------------------------------------------------
    localparam logic [15:0] RES_DEF = 16'h8000;
    localparam logic [15:0] RES_ABORT = 16'hffff;
    localparam logic [4:0] NCELL_RST = 5'h10;

    // -------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------
    typedef struct packed {
        logic [3:0] thr;
        logic [1:0] sink;
        logic [2:0] sel;
    } ctrl_t;

    typedef struct packed {
        logic [2:0] bb_filt;
        logic [2:0] cell_filt;
        logic [1:0] settle;
        logic [4:0] aux_sel;
        logic [4:0] num_cell;
    } cfg_t;

    typedef struct packed {
        logic valid;
        logic [3:0] chan;
        logic [15:0] value;
    } sample_t;

    typedef struct packed {
        logic aux_sel_bad;
        logic over_count;
        logic bb_bad;
        logic main_bad;
        logic aux_adc_bad;
        logic cb_bad;
        logic sw_bad;
    } chk_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01
    } state_t;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [4:0] popcount(input logic [15:0] m);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < NCELL; i++) begin
            n = n + {4'h0, m[i]};
        end
        return n;
    endfunction : popcount

    // open wire shows as a value below the threshold step
    function automatic logic ow_low(input logic [15:0] v,
                                    input logic [3:0] thr);
        return v < {thr, 12'h000};
    endfunction : ow_low

endpackage : ow_pkg

/* src/ow_setup_check.sv */
// setup screening for comparison start: one flag per group of invalid conditions
// assumes config inputs are stable registers of the parent
module ow_setup_check (
    // configuration
    input wire ow_pkg::cfg_t cfg_i,
    input wire logic [15:0] bb_pos_i,
    input wire logic [15:0] sw_sel_i,
    // converter and balancing state
    input wire logic main_on_i,
    input wire logic main_cont_i,
    input wire logic aux_on_i,
    input wire logic aux_cont_i,
    input wire logic cb_active_i,
    input wire logic cb_paused_i,
    // result
    output ow_pkg::chk_t chk_o
);

    logic locked;
    logic [3:0] lidx;
    logic [4:0] lim;
    logic triple;

    // lock codes 1..16, zero means all channels
    assign locked = (cfg_i.aux_sel != 5'h00) && (cfg_i.aux_sel <= lim);
    assign lim = 5'(ow_pkg::NCELL);
    assign lidx = 4'(cfg_i.aux_sel - 5'h01);
    assign triple = |(sw_sel_i & (sw_sel_i >> 1) & (sw_sel_i >> 2));

    // codes past 16 give no aux measurement at all
    assign chk_o.aux_sel_bad = cfg_i.aux_sel > lim;
    assign chk_o.over_count = locked && (cfg_i.aux_sel > cfg_i.num_cell);
    // adjacency, bottom cell, count, lock onto a bus-bar channel
    assign chk_o.bb_bad = (|(bb_pos_i & (bb_pos_i >> 1))) | bb_pos_i[0]
        | (ow_pkg::popcount(bb_pos_i) > 5'(ow_pkg::BB_MAX_POS))
        | (locked & bb_pos_i[lidx]);
    assign chk_o.main_bad = ~main_on_i | ~main_cont_i;
    assign chk_o.aux_adc_bad = ~aux_on_i | ~aux_cont_i;
    assign chk_o.cb_bad = cb_active_i & ~cb_paused_i;
    assign chk_o.sw_bad = (ow_pkg::popcount(sw_sel_i)
        > 5'(ow_pkg::SW_MAX_ON)) | triple;

endmodule : ow_setup_check

/* test/ow_check_ctrl_assertions.sv */
// port assertions for the open-wire and switch check block
// assumes binding into ow_check_ctrl on its single core clock
module ow_check_ctrl_assertions (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // pins and status
    input wire logic [15:0] sense_sink_o,
    input wire logic sense_source_o,
    input wire logic [15:0] bal_sink_o,
    input wire logic bal_source_o,
    input wire logic busbar_sink_o,
    input wire logic [2:0] busbar_gain_o,
    input wire logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    sequence s_setup;
        psel_i && !penable_i && ce_i;
    endsequence
    property p_ready; s_setup |=> pready_o; endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    property p_pulse; pready_o |=> !pready_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_err; pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_idle; !pready_o |-> prdata_o == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data leaks");
    // ------------------------------------------------------------
    // pins and start
    // ------------------------------------------------------------
    property p_gain; busbar_gain_o == ow_pkg::BB_GAIN_X5; endproperty
    a_gain: assert property (p_gain) else $error("gain");
    property p_vc; sense_source_o == (|sense_sink_o); endproperty
    a_vc: assert property (p_vc) else $error("sense pins");
    property p_cb; bal_source_o == (|bal_sink_o); endproperty
    a_cb: assert property (p_cb) else $error("balance pins");
    // one sink code at a time, so sense pins never on together with balance or bus-bar pins
    property p_one;
        !(sense_source_o && (bal_source_o || busbar_sink_o));
    endproperty
    a_one: assert property (p_one) else $error("sinks overlap");
    // a run only starts from a bus write
    property p_busy; $rose(busy_o) |-> $past(pready_o, 2) || $past(pready_o);
    endproperty
    a_busy: assert property (p_busy) else $error("start");
endmodule : ow_check_ctrl_assertions

bind ow_check_ctrl ow_check_ctrl_assertions i_chk (.ref_clk_i, .rstn_i,
    .ce_i, .psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o,
    .sense_sink_o, .sense_source_o, .bal_sink_o, .bal_source_o,
    .busbar_sink_o, .busbar_gain_o, .busy_o);

/* test/testbench.sv */
// self-checking bench for ow_check_ctrl over apb
// assumes the bound checker; ce and continuous modes high until the last two checks
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, m_on = 1'b1, cb_act = 1'b0;
    logic ce = 1'b1, m_cont = 1'b1, paused = 1'b0, vsrc, bsrc;
    logic [2:0] bbf, cf;
    logic [1:0] stl;
    logic [11:0] addr = 12'h000;
    logic [31:0] wd = 32'h0, rd = 32'h0, prdata;
    logic pready, pslverr, busy, err;
    ow_pkg::sample_t msmp = '0, asmp = '0, bsmp = '0;
    int n_fail = 0, check_count = 0, cyc = 0;
    // bad setups: main off, balancing on, cfg | bus-bar | switches
    localparam logic [47:0] ROWS [10] = '{48'h4004_0000_0001,
        48'h0004_0000_0007, 48'h0010_0000_d555,
        48'h0004_0001_0001, 48'h0004_0006_0001,
        48'h0010_0154_0001, 48'h0064_0004_0001,
        48'h00a4_0000_0001, 48'h0284_0000_0001,
        48'h8004_0000_0001};
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    ow_check_ctrl i_dut (.ref_clk_i, .rstn_i, .ce_i(ce), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wd),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .main_on_i(m_on), .main_cont_i(m_cont), .aux_on_i(m_on),
        .aux_cont_i(1'b1), .cb_active_i(cb_act), .cb_paused_i(paused),
        .main_sample_i(msmp), .aux_sample_i(asmp), .busbar_sample_i(bsmp),
        .sense_sink_o(), .sense_source_o(vsrc), .bal_sink_o(),
        .bal_source_o(bsrc), .busbar_sink_o(), .aux_settling_o(stl),
        .cell_filter_o(cf), .busbar_filter_o(bbf), .busbar_gain_o(),
        .busy_o(busy));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // request held until the edge that sees pready
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= d;
        @(posedge ref_clk_i);
        pen <= 1'b1;
        do @(posedge ref_clk_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rc
    // bounded status poll for one flag
    task automatic poll(input int b);
        rd = 32'h0;
        for (int i = 0; i < 40 && rd[b] !== 1'b1; i++) begin
            xfer(1'b0, ow_pkg::A_STAT, 32'h0);
        end
    endtask : poll
    // four channels, only channel index 1 under the threshold
    task automatic feed(input logic aux, input logic [15:0] lo);
        ow_pkg::sample_t s;
        for (int i = 0; i < 8 && busy !== 1'b1; i++) @(posedge ref_clk_i);
        for (int c = 0; c < 4; c++) begin
            s = '{1'b1, 4'(c), c == 1 ? lo : 16'h9000};
            @(posedge ref_clk_i);
            if (aux) asmp <= s;
            else msmp <= s;
        end
        @(posedge ref_clk_i);
        msmp <= '0;
        asmp <= '0;
    endtask : feed
    // hang guard
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        rc(ow_pkg::A_CFG, 32'h10);
        rc(ow_pkg::A_AUXRES, 32'h8000);
        rc(ow_pkg::A_BBRES, 32'h8000);
        xfer(1'b0, 12'hff0, 32'h0);
        chk({31'h0, err}, 32'h1);
        foreach (ROWS[i]) begin
            m_on <= ~ROWS[i][47];
            cb_act <= ROWS[i][46];
            wr(ow_pkg::A_CFG, {18'h0, ROWS[i][45:32]});
            wr(ow_pkg::A_BBPOS, {16'h0, ROWS[i][31:16]});
            wr(ow_pkg::A_SWSEL, {16'h0, ROWS[i][15:0]});
            wr(ow_pkg::A_CTRL, 32'h204);
            poll(0);
            chk(rd, 32'h07);
            rc(ow_pkg::A_SWRES, 32'hffff);
            rc(ow_pkg::A_AUXRES, 32'h8000);
            wr(ow_pkg::A_STAT, 32'h1f);
            chk({31'h0, busy}, 32'h0);
        end
        m_on <= 1'b1;
        wr(ow_pkg::A_CFG, 32'h4);
        wr(ow_pkg::A_CTRL, 32'h10a);
        wr(ow_pkg::A_CTRL, 32'h30a);
        feed(1'b0, 16'h1000);
        chk({30'h0, vsrc, bsrc}, 32'h2);
        poll(3);
        chk(rd, 32'h08);
        rc(ow_pkg::A_VCRES, 32'h2);
        rc(ow_pkg::A_DPRI, 32'h8000);
        rc(12'h044, 32'h1000);
        wr(ow_pkg::A_STAT, 32'h1f);
        wr(ow_pkg::A_CFG, 32'h2b844);
        wr(ow_pkg::A_CTRL, 32'h313);
        feed(1'b1, 16'h2000);
        chk({30'h0, vsrc, bsrc}, 32'h1);
        chk({24'h0, bbf, cf, stl}, 32'hae);
        poll(4);
        chk(rd, 32'h10);
        wr(ow_pkg::A_CTRL, 32'h100);
        rc(ow_pkg::A_CBRES, 32'h2);
        rc(ow_pkg::A_DSEC, 32'h2000);
        rc(ow_pkg::A_AUXRES, 32'h2000);
        chk({30'h0, vsrc, bsrc}, 32'h0);
        // locked select: an abort must bring back the default
        cb_act <= 1'b1;
        wr(ow_pkg::A_CTRL, 32'h204);
        rc(ow_pkg::A_AUXRES, 32'h8000);
        // paused balancing, no switch chosen: run ends at once
        paused <= 1'b1;
        wr(ow_pkg::A_SWSEL, 32'h0);
        wr(ow_pkg::A_STAT, 32'h1f);
        wr(ow_pkg::A_CTRL, 32'h204);
        poll(2);
        chk(rd, 32'h06);
        // main converter on but not continuous
        m_cont <= 1'b0;
        wr(ow_pkg::A_STAT, 32'h1f);
        wr(ow_pkg::A_CTRL, 32'h202);
        poll(0);
        chk(rd, 32'h09);
        // bus-bar sample kept; a frozen cycle must not take one
        bsmp <= '{1'b1, 4'h0, 16'h1234};
        @(posedge ref_clk_i);
        bsmp <= '{1'b1, 4'h0, 16'h5678};
        ce <= 1'b0;
        @(posedge ref_clk_i);
        bsmp <= '0;
        ce <= 1'b1;
        rc(ow_pkg::A_BBRES, 32'h1234);
        end_sim();
    end
endmodule : testbench
